// file: shared/ibp_map.svh
`ifndef IBP_MAP_SVH
`define IBP_MAP_SVH

// Register offsets on the control serial interface
`define IBP_OFF_STS3 8'h54
`define IBP_OFF_MSK3 8'h55
`define IBP_OFF_PIN0 8'h60

// Reset values and implemented bits
`define IBP_STS3_RST 8'h00
`define IBP_MSK3_RST 8'hff
`define IBP_STS3_IMPL 8'h9f
`define IBP_PIN0_WMASK 8'hbd

// Status and mask field positions
`define IBP_B_POWERDOWN_RESET_INPUT 7
`define IBP_B_WDOG 4
`define IBP_B_P5F 3
`define IBP_B_P5R 2
`define IBP_B_P4F 1
`define IBP_B_P4R 0

// Pin 0 configuration field positions
`define IBP_B_SLEEP 7
`define IBP_B_RSVD 6
`define IBP_B_ODEN 5
`define IBP_B_DEB 4
`define IBP_B_PDEN 3
`define IBP_B_DIR 2
`define IBP_B_LVL 1
`define IBP_B_SET 0

// Timing
`define IBP_CLK_MHZ 125
`define IBP_FAST_TICK_NS 30500
`define IBP_FAST_FILT_NS 91500
`define IBP_SLOW_TICK_MS 50
`define IBP_SLOW_FILT_MS 150
`define IBP_FAST_TICK_CYC ((`IBP_FAST_TICK_NS * `IBP_CLK_MHZ) / 1000)
`define IBP_SLOW_TICK_CYC (`IBP_SLOW_TICK_MS * `IBP_CLK_MHZ * 1000)
`define IBP_DEB_SAMPLES (`IBP_FAST_FILT_NS / `IBP_FAST_TICK_NS)

`endif

// file: shared/ibp_pkg.sv
`default_nettype none
package ibp_pkg;
  typedef logic [7:0] ibp_byte_t;
  typedef enum logic [0:0] {
    IBP_LVL_LOW = 1'b0,
    IBP_LVL_HIGH = 1'b1
  } ibp_level_e;
endpackage
`default_nettype wire

// file: hw/ibp_debounce.sv
`timescale 1ns/1ps
`default_nettype none
`include "ibp_map.svh"
module ibp_debounce #(
  parameter int FAST_TICK_CYC = `IBP_FAST_TICK_CYC,
  parameter int SLOW_TICK_CYC = `IBP_SLOW_TICK_CYC,
  parameter int SAMPLES = `IBP_DEB_SAMPLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Filter
  input wire logic slow_sel,
  input wire logic raw_in,
  output logic level
);
  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  logic [23:0] lim;
  logic tick;
  logic [SAMPLES-1:0] hist_reg;
  logic [SAMPLES-1:0] hist_next;
  logic all_hi;
  logic all_lo;
  ibp_pkg::ibp_level_e lvl_reg;
  ibp_pkg::ibp_level_e lvl_next;

  // Sample rate follows the select at once; a switch mid-period stretches or shortens one tick
  assign lim = slow_sel ? 24'(SLOW_TICK_CYC - 1) : 24'(FAST_TICK_CYC - 1); // [RULE12]
  assign tick = (cnt_reg >= lim);
  assign cnt_next = tick ? 24'h000000 : cnt_reg + 24'h000001;
  assign hist_next = tick ? {hist_reg[SAMPLES-2:0], raw_in} : hist_reg;
  assign all_hi = &hist_next;
  assign all_lo = ~|hist_next;
  assign level = (lvl_reg == ibp_pkg::IBP_LVL_HIGH);

  always_comb begin
    lvl_next = lvl_reg;
    case (lvl_reg)
      ibp_pkg::IBP_LVL_LOW: if (tick && all_hi) lvl_next = ibp_pkg::IBP_LVL_HIGH; // [RULE12]
      ibp_pkg::IBP_LVL_HIGH: if (tick && all_lo) lvl_next = ibp_pkg::IBP_LVL_LOW; // [RULE12]
      default: lvl_next = ibp_pkg::IBP_LVL_HIGH;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_reg <= 24'h000000;
      hist_reg <= {SAMPLES{1'b1}};
      lvl_reg <= ibp_pkg::IBP_LVL_HIGH;
    end else begin
      cnt_reg <= cnt_next;
      hist_reg <= hist_next;
      lvl_reg <= lvl_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_DEB_ON_TICK: assert property ((lvl_reg != lvl_next) |-> tick) // [RULE12]
    else $error("Debounced level moved between sample ticks");
  AST_DEB_FILTER: assert property ($rose(level) |-> $past(&hist_next)) // [RULE12]
    else $error("Debounced level rose without a full run of high samples");
endmodule
`default_nettype wire

// file: hw/ibp_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ibp_map.svh"
// Summary of operation
// [RULE1] Status flags set on their event and hold until software writes one.
// [RULE2] Bit 7 records power-down input high; bit 4 records watchdog event.
// [RULE3] Bits 3,2 flag pin 5 fall and rise; bits 1,0 pin 4.
// [RULE4] Status flags reset to zero only by the full reset.
// [RULE5] A set mask bit still updates the flag but keeps the line quiet.
// [RULE6] A clear mask bit updates the flag and raises the interrupt line.
// [RULE7] Mask register mirrors status layout, resets to all ones, general domain.
// [RULE8] Sleep-force bit drives pin 0 low as output while asleep.
// [RULE9] Bit 5 selects push-pull when zero, open-drain when one.
// [RULE10] Output-mode and direction defaults come from the boot configuration.
// [RULE11] Shutdown reset forces open-drain when pin 0 is in power-up sequence.
// [RULE12] Debounce bit picks 91.5 us at 30.5 us rate, or 150 ms at 50 ms.
// [RULE13] Bit 3 enables the pad pulldown; resets to zero.
// [RULE14] Bit 2 makes the pad an input when zero, output when one.
// [RULE15] Read-only bit 1 returns the pad level; reads one after reset.
// [RULE16] Bit 0 is the output level; shutdown reset clears it in power-up sequence.
// [RULE17] Bit 6 is reserved and reads zero; register in general domain.
// [RULE18] Line asserts while any unmasked flag is set; writing zero changes nothing.
module ibp_regs #(
  parameter int SLOW_TICK_CYC = `IBP_SLOW_TICK_CYC
) (
  // Clock and resets
  input wire logic clk,
  input wire logic rstn,
  input wire logic general_rst_n,
  input wire logic shutdown_reset_n,
  // Boot configuration
  input wire logic boot_open_drain,
  input wire logic boot_output_dir,
  input wire logic pin0_in_powerup_seq,
  // Register port behind the control serial interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Events
  input wire logic powerdown_reset_input,
  input wire logic watchdog_event,
  input wire logic pin5_fall_event,
  input wire logic pin5_rise_event,
  input wire logic pin4_fall_event,
  input wire logic pin4_rise_event,
  // Interrupt
  output logic irq_out_line,
  // Pin 0 pad
  input wire logic sleep_mode,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_n,
  output logic pulldown_enable
);
  function automatic logic ibp_hit(input logic [7:0] a, input logic [7:0] off);
    ibp_hit = (a == off);
  endfunction

  ibp_pkg::ibp_byte_t sts_reg;
  ibp_pkg::ibp_byte_t sts_next;
  ibp_pkg::ibp_byte_t msk_reg;
  ibp_pkg::ibp_byte_t msk_next;
  ibp_pkg::ibp_byte_t pin_reg;
  ibp_pkg::ibp_byte_t pin_next;
  ibp_pkg::ibp_byte_t pin_wr;
  ibp_pkg::ibp_byte_t pin_base;
  ibp_pkg::ibp_byte_t pin_boot;
  ibp_pkg::ibp_byte_t pin_view;
  ibp_pkg::ibp_byte_t evt_vec;
  ibp_pkg::ibp_byte_t clr_vec;
  ibp_pkg::ibp_byte_t rdata_next;
  logic wr_sts;
  logic wr_msk;
  logic wr_pin;
  logic rd_sts;
  logic rd_msk;
  logic rd_pin;
  logic gen_rst;
  logic pin_rst_n;
  logic shut_hit;
  logic irq_next;
  logic force_low;
  logic oe_n_next;
  logic out_next;
  logic pad_level;
  logic irq_reg;
  logic pad_out_reg;
  logic pad_oe_n_reg;
  logic pulldown_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;

  // Address decode
  assign wr_sts = reg_wr && ibp_hit(reg_addr, `IBP_OFF_STS3);
  assign wr_msk = reg_wr && ibp_hit(reg_addr, `IBP_OFF_MSK3);
  assign wr_pin = reg_wr && ibp_hit(reg_addr, `IBP_OFF_PIN0);
  assign rd_sts = ibp_hit(reg_addr, `IBP_OFF_STS3);
  assign rd_msk = ibp_hit(reg_addr, `IBP_OFF_MSK3);
  assign rd_pin = ibp_hit(reg_addr, `IBP_OFF_PIN0);

  // Reset domains
  assign gen_rst = !rstn || !general_rst_n;
  assign pin_rst_n = rstn && general_rst_n;
  assign shut_hit = !shutdown_reset_n && pin0_in_powerup_seq;

  // Event sources, reserved positions tied off
  assign evt_vec = {
    powerdown_reset_input, // [RULE2]
    2'b00,
    watchdog_event, // [RULE2]
    pin5_fall_event, // [RULE3]
    pin5_rise_event, // [RULE3]
    pin4_fall_event, // [RULE3]
    pin4_rise_event // [RULE3]
  };

  // Write-one-to-clear; an event in the clearing cycle wins so it is never lost
  assign clr_vec = wr_sts ? reg_wdata : 8'h00; // [RULE18]
  assign sts_next = ((sts_reg & ~clr_vec) | evt_vec) & `IBP_STS3_IMPL; // [RULE1]

  // Mask register
  assign msk_next = wr_msk ? reg_wdata : msk_reg; // [RULE7]

  // Interrupt line sees flags one cycle after they land
  assign irq_next = |(sts_reg & ~msk_reg); // [RULE5] [RULE6] [RULE18]

  // Pin 0 configuration
  assign pin_boot = (8'(boot_open_drain) << `IBP_B_ODEN)
                  | (8'(boot_output_dir) << `IBP_B_DIR); // [RULE10]
  assign pin_wr = wr_pin ? (reg_wdata & `IBP_PIN0_WMASK) : pin_reg; // [RULE17]
  assign pin_base = gen_rst ? pin_boot : pin_wr;
  // Shutdown reset is applied on top so it also holds during a general reset
  assign pin_next = shut_hit
    ? ((pin_base | (8'h01 << `IBP_B_ODEN)) & ~(8'h01 << `IBP_B_SET)) // [RULE11] [RULE16]
    : pin_base;
  assign pin_view = pin_reg | (8'(pad_level) << `IBP_B_LVL); // [RULE15]

  // Pad drive
  assign force_low = sleep_mode && pin_reg[`IBP_B_SLEEP]; // [RULE8]
  assign oe_n_next = force_low ? 1'b0 // [RULE8]
    : !pin_reg[`IBP_B_DIR] ? 1'b1 // [RULE14]
    : pin_reg[`IBP_B_ODEN] ? pin_reg[`IBP_B_SET] // [RULE9]
    : 1'b0;
  assign out_next = !force_low && pin_reg[`IBP_B_DIR]
    && !pin_reg[`IBP_B_ODEN] && pin_reg[`IBP_B_SET]; // [RULE9] [RULE16]

  // Read mux; unmapped offsets read zero
  assign rdata_next = rd_sts ? sts_reg
    : rd_msk ? msk_reg
    : rd_pin ? pin_view
    : 8'h00;

  // Outputs straight from flops
  assign irq_out_line = irq_reg;
  assign pad_out = pad_out_reg;
  assign pad_oe_n = pad_oe_n_reg;
  assign pulldown_enable = pulldown_reg;
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  ibp_debounce #(
    .SLOW_TICK_CYC(SLOW_TICK_CYC)
  ) u_deb (
    .clk(clk),
    .rstn(pin_rst_n),
    .slow_sel(pin_reg[`IBP_B_DEB]),
    .raw_in(pad_in),
    .level(pad_level)
  );

  // Status lives in the full domain only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sts_reg <= `IBP_STS3_RST; // [RULE4]
    end else begin
      sts_reg <= sts_next;
    end
  end

  always_ff @(posedge clk) begin
    if (gen_rst) begin
      msk_reg <= `IBP_MSK3_RST; // [RULE7]
    end else begin
      msk_reg <= msk_next;
    end
  end

  always_ff @(posedge clk) begin
    pin_reg <= pin_next;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 8'h00;
      pulldown_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
      rvalid_reg <= reg_rd;
      rdata_reg <= reg_rd ? rdata_next : rdata_reg;
      pulldown_reg <= pin_reg[`IBP_B_PDEN]; // [RULE13]
    end
  end

  always_ff @(posedge clk) begin
    if (gen_rst) begin
      pad_out_reg <= 1'b0;
      pad_oe_n_reg <= 1'b1;
    end else begin
      pad_out_reg <= out_next;
      pad_oe_n_reg <= oe_n_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_flag_kept;
    (sts_reg & ~clr_vec) != 8'h00;
  endsequence

  sequence s_quiet;
    (sts_reg & ~msk_reg) == 8'h00;
  endsequence

  sequence s_pin_read;
    reg_rd && rd_pin;
  endsequence

  sequence s_output_active;
    !force_low && pin_reg[`IBP_B_DIR];
  endsequence

  AST_STS_STICKY: assert property (s_flag_kept |=> // [RULE1]
    (($past(sts_reg) & ~$past(clr_vec)) & ~sts_reg) == 8'h00)
    else $error("A status flag dropped without a one written to it");

  AST_SET_WINS: assert property ((wr_sts && (reg_wdata & evt_vec) != 8'h00) |=> // [RULE1]
    (sts_reg & $past(evt_vec) & `IBP_STS3_IMPL) == ($past(evt_vec) & `IBP_STS3_IMPL))
    else $error("An event in the clearing cycle was lost");

  AST_POWERDOWN_RESET_INPUT_SEEN: assert property (powerdown_reset_input |=> sts_reg[`IBP_B_POWERDOWN_RESET_INPUT]) // [RULE2]
    else $error("Power-down input high not recorded in bit 7");

  AST_WDOG_SEEN: assert property (watchdog_event |=> sts_reg[`IBP_B_WDOG]) // [RULE2]
    else $error("Watchdog event not recorded in bit 4");

  AST_PIN_EDGES: assert property ( // [RULE3]
    {pin5_fall_event, pin5_rise_event, pin4_fall_event, pin4_rise_event} != 4'h0
    |=> (sts_reg[3:0] & $past(evt_vec[3:0])) == $past(evt_vec[3:0]))
    else $error("Pin 4 or pin 5 edge not recorded");

  AST_RSVD_CLEAR: assert property (sts_reg[6:5] == 2'b00) // [RULE3]
    else $error("Reserved status bits were set");

  AST_STS_RESET: assert property ($rose(rstn) |-> sts_reg == `IBP_STS3_RST) // [RULE4]
    else $error("Status not cleared by full reset");

  AST_LIGHT_RESET_KEEPS: assert property ( // [RULE4]
    (!general_rst_n || !shutdown_reset_n) && !wr_sts |=> ((sts_reg & $past(sts_reg)) == $past(sts_reg)))
    else $error("A lighter reset cleared status flags");

  AST_MASKED_QUIET: assert property (s_quiet |=> !irq_out_line) // [RULE5]
    else $error("Interrupt line raised with every set flag masked");

  AST_UNMASKED_FIRES: assert property ((sts_reg & ~msk_reg) != 8'h00 |=> irq_out_line) // [RULE6]
    else $error("Unmasked flag did not raise the interrupt line");

  AST_MASK_GEN_RESET: assert property (!general_rst_n |=> msk_reg == `IBP_MSK3_RST) // [RULE7]
    else $error("Mask register not set to all ones by general reset");

  AST_MASK_WRITE: assert property (wr_msk && general_rst_n |=> msk_reg == $past(reg_wdata)) // [RULE7]
    else $error("Mask write not stored");

  AST_SLEEP_FORCE: assert property (force_low && general_rst_n |=> !pad_oe_n && !pad_out) // [RULE8]
    else $error("Sleep force did not drive the pad low");

  AST_OPEN_DRAIN: assert property ( // [RULE9]
    s_output_active ##0 (pin_reg[`IBP_B_ODEN] && pin_reg[`IBP_B_SET] && general_rst_n)
    |=> pad_oe_n && !pad_out)
    else $error("Open-drain output drove a high level");

  AST_PUSH_PULL: assert property ( // [RULE9]
    s_output_active ##0 (!pin_reg[`IBP_B_ODEN] && general_rst_n)
    |=> !pad_oe_n && (pad_out == $past(pin_reg[`IBP_B_SET])))
    else $error("Push-pull output did not follow the set bit");

  AST_BOOT_LOAD: assert property (!general_rst_n && shutdown_reset_n |=> // [RULE10]
    pin_reg[`IBP_B_ODEN] == $past(boot_open_drain)
    && pin_reg[`IBP_B_DIR] == $past(boot_output_dir))
    else $error("Boot defaults not loaded into pin 0 register");

  AST_SHUTDOWN_OD: assert property (shut_hit |=> // [RULE11] [RULE16]
    pin_reg[`IBP_B_ODEN] && !pin_reg[`IBP_B_SET])
    else $error("Shutdown reset did not force open-drain and low level");

  AST_PULLDOWN: assert property (1'b1 |=> pulldown_enable == $past(pin_reg[`IBP_B_PDEN])) // [RULE13]
    else $error("Pulldown output does not follow bit 3");

  AST_DIR_INPUT: assert property ( // [RULE14]
    !force_low && !pin_reg[`IBP_B_DIR] && general_rst_n |=> pad_oe_n && !pad_out)
    else $error("Pad driven while configured as input");

  AST_LEVEL_READ: assert property (s_pin_read |=> // [RULE15]
    reg_rvalid && reg_rdata[`IBP_B_LVL] == $past(pad_level))
    else $error("Pad level bit does not return the pad state");

  AST_RSVD_PIN_ZERO: assert property (s_pin_read |=> !reg_rdata[`IBP_B_RSVD]) // [RULE17]
    else $error("Reserved pin 0 bit read as one");

  AST_WRITE_ZERO: assert property (wr_sts && reg_wdata == 8'h00 |=> // [RULE18]
    (sts_reg & $past(sts_reg)) == $past(sts_reg))
    else $error("Writing zero cleared a status flag");
endmodule
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ibp_map.svh"
module tb;
  // Short slow tick keeps the 150 ms filter case inside the run
  localparam int SLOW = 20;
  logic clk;
  logic rstn, general_rst_n, shutdown_reset_n;
  logic boot_open_drain, boot_output_dir, pin0_in_powerup_seq;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ev, rv;
  logic reg_rvalid, irq_out_line, sleep_mode, pad_in, pad_out, pad_oe_n, pulldown_enable;
  int error_cnt, num_checks;
  int bits[6] = '{0, 1, 2, 3, 4, 7};
  logic [7:0] pw[7] = '{8'h04, 8'h05, 8'h25, 8'h24, 8'h00, 8'h85, 8'h85};
  logic sl[7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [1:0] po[7] = '{2'b00, 2'b01, 2'b10, 2'b00, 2'b10, 2'b00, 2'b01};

  ibp_regs #(.SLOW_TICK_CYC(SLOW)) uut (
    .clk(clk), .rstn(rstn), .general_rst_n(general_rst_n),
    .shutdown_reset_n(shutdown_reset_n), .boot_open_drain(boot_open_drain),
    .boot_output_dir(boot_output_dir), .pin0_in_powerup_seq(pin0_in_powerup_seq),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .powerdown_reset_input(ev[7]),
    .watchdog_event(ev[4]), .pin5_fall_event(ev[3]), .pin5_rise_event(ev[2]),
    .pin4_fall_event(ev[1]), .pin4_rise_event(ev[0]), .irq_out_line(irq_out_line),
    .sleep_mode(sleep_mode), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pulldown_enable(pulldown_enable)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Events may share the write cycle to test flag-set against clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    ev <= e;
    @(posedge clk);
    reg_wr <= 1'b0;
    ev <= 8'h00;
  endtask

  task automatic pulse(input logic [7:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 8'h00;
  endtask

  // Read data is valid exactly one cycle after the strobe is taken
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
    rv = reg_rdata;
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(name, rv, exp);
  endtask

  task automatic irq_after(input logic exp);
    @(posedge clk);
    #1;
    chk("irq", {7'h00, irq_out_line}, {7'h00, exp});
  endtask

  task automatic poll_level(input logic exp, input int gap, input int tries);
    for (int i = 0; i < tries; i++) begin
      rd(`IBP_OFF_PIN0);
      if (rv[1] === exp) break;
      repeat (gap) @(posedge clk);
    end
    chk("pad level", {7'h00, rv[1]}, {7'h00, exp});
  endtask

  initial begin
    {rstn, reg_wr, reg_rd, sleep_mode, pin0_in_powerup_seq, boot_output_dir} = 6'h00;
    {general_rst_n, shutdown_reset_n, pad_in, boot_open_drain} = 4'hf;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ev = 8'h00;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rdc("status", `IBP_OFF_STS3, `IBP_STS3_RST);
    rdc("mask", `IBP_OFF_MSK3, `IBP_MSK3_RST);
    rdc("pin0", `IBP_OFF_PIN0, 8'h22);
    chk("pulldown", {7'h00, pulldown_enable}, 8'h00);
    chk("oe_n", {7'h00, pad_oe_n}, 8'h01);
    rdc("unmapped", 8'h56, 8'h00);
    foreach (bits[i]) begin
      pulse(8'h01 << bits[i]);
      irq_after(1'b0);
      rdc("status", `IBP_OFF_STS3, 8'h01 << bits[i]);
      wr(`IBP_OFF_STS3, 8'h01 << bits[i], 8'h00);
      rdc("status", `IBP_OFF_STS3, 8'h00);
      wr(`IBP_OFF_MSK3, ~(8'h01 << bits[i]), 8'h00);
      pulse(8'h01 << bits[i]);
      irq_after(1'b1);
      wr(`IBP_OFF_STS3, 8'h00, 8'h00);
      rdc("status", `IBP_OFF_STS3, 8'h01 << bits[i]);
      chk("irq", {7'h00, irq_out_line}, 8'h01);
      wr(`IBP_OFF_STS3, 8'h01 << bits[i], 8'h00);
      irq_after(1'b0);
      wr(`IBP_OFF_MSK3, 8'hff, 8'h00);
    end
    pulse(8'hff);
    wr(`IBP_OFF_STS3, 8'h01, 8'h01);
    rdc("status", `IBP_OFF_STS3, `IBP_STS3_IMPL);
    wr(`IBP_OFF_STS3, 8'hff, 8'h00);
    rdc("status", `IBP_OFF_STS3, 8'h00);
    wr(`IBP_OFF_MSK3, 8'h5a, 8'h00);
    wr(8'h56, 8'h00, 8'h00);
    rdc("mask", `IBP_OFF_MSK3, 8'h5a);
    wr(`IBP_OFF_PIN0, 8'hff, 8'h00);
    rdc("pin0", `IBP_OFF_PIN0, 8'hbf);
    chk("pulldown", {7'h00, pulldown_enable}, 8'h01);
    foreach (pw[i]) begin
      @(posedge clk);
      sleep_mode <= sl[i];
      wr(`IBP_OFF_PIN0, pw[i], 8'h00);
      @(posedge clk);
      #1;
      chk("pad", {6'h00, pad_oe_n, pad_out}, {6'h00, po[i]});
    end
    chk("pulldown", {7'h00, pulldown_enable}, 8'h00);
    // Fast filter needs three samples 3812 cycles apart
    wr(`IBP_OFF_PIN0, 8'h00, 8'h00);
    @(posedge clk);
    pad_in <= 1'b0;
    repeat (7000) @(posedge clk);
    rdc("fast early", `IBP_OFF_PIN0, 8'h02);
    poll_level(1'b0, 100, 100);
    wr(`IBP_OFF_PIN0, 8'h10, 8'h00);
    @(posedge clk);
    pad_in <= 1'b1;
    repeat (30) @(posedge clk);
    rdc("slow early", `IBP_OFF_PIN0, 8'h10);
    poll_level(1'b1, 5, 700);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      pin0_in_powerup_seq <= (k == 0);
      wr(`IBP_OFF_PIN0, 8'h05, 8'h00);
      @(posedge clk);
      shutdown_reset_n <= 1'b0;
      @(posedge clk);
      shutdown_reset_n <= 1'b1;
      rdc("shutdown", `IBP_OFF_PIN0, (k == 0) ? 8'h26 : 8'h07);
    end
    wr(`IBP_OFF_MSK3, 8'h00, 8'h00);
    pulse(8'h01);
    @(posedge clk);
    general_rst_n <= 1'b0;
    boot_open_drain <= 1'b0;
    boot_output_dir <= 1'b1;
    repeat (2) @(posedge clk);
    general_rst_n <= 1'b1;
    rdc("status", `IBP_OFF_STS3, 8'h01);
    rdc("mask", `IBP_OFF_MSK3, `IBP_MSK3_RST);
    rdc("pin0", `IBP_OFF_PIN0, 8'h06);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdc("status", `IBP_OFF_STS3, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
